// >>> dv/digit_to_bit_decoder_tb_top.sv
`timescale 1ns/10ps
module digit_to_bit_decoder_tb_top;
	logic        clk = 0, rst_b = 0, exec_cond = 1, hsel = 0, hwrite = 0;
	logic        hready, hresp, mem_we, busy, error_flag;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, q;
	logic [15:0] mem_addr, mem_wdata;
	logic [15:0] ec [6] = '{16'h2000, 16'h0004, 16'h1002, 16'h0030, 16'h0001, 16'h0001};
	logic [15:0] ed [6] = '{16'h0010, 16'h0010, 16'h0010, 16'h0010, 16'h00a0, 16'h0099};
	int          num_errors = 0, n_compared = 0, k;
	dtb_decoder uut (.clk(clk), .rst_b(rst_b), .ce(1'b1), .exec_cond(exec_cond), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .mem_we(mem_we),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .busy(busy), .error_flag(error_flag));
	dtb_mem u_mem (.clk(clk), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata));
	initial begin
		forever #50 clk = ~clk;
	end
	task xf(input w, input [7:0] a, input [31:0] wd);
		hsel <= 1; haddr <= {24'h0, a}; hwrite <= w; htrans <= 2'h2;
		do @(posedge clk); while (!hready);
		htrans <= 2'h0; hsel <= 0; hwdata <= wd;
		do @(posedge clk); while (!hready);
		q = hrdata;
	endtask
	task cmp(input [15:0] g, e);
		n_compared++;
		if (g !== e) begin
			num_errors++;
			$display("Error %0t: got %h exp %h", $time, g, e);
		end
	endtask
	task run(input [15:0] s, c, d, input [1:0] m);
		int t;
		for (t = 0; t < 256; t++) u_mem.m[t] = 16'hdead;
		xf(1, 8'h00, {16'h0, s}); xf(1, 8'h04, {16'h0, c});
		xf(1, 8'h08, {16'h0, d}); xf(1, 8'h14, {30'h0, m});
		t = 0;
		while ((busy || t < 3) && t < 100) begin
			@(posedge clk); t++;
		end
		repeat (2) @(posedge clk);
		#1;
	endtask
	task t_nib;
		run(16'hf0a5, 16'h0033, 16'h0010, 2'h1);
		for (k = 0; k < 4; k++) cmp(u_mem.m[16+k], 16'h1 << 4'(16'hf0a5 >> ((3+k)%4)*4));
		cmp(u_mem.m[20], 16'hdead);
	endtask
	task t_byte;
		run(16'h3a7f, 16'h1011, 16'h0040, 2'h1);
		for (k = 0; k < 33; k++) cmp(u_mem.m[64+k], k == 3 ? 16'h0400 : k == 23 ? 16'h8000 :
			k == 32 ? 16'hdead : 16'h0000);
	endtask
	task t_cond;
		exec_cond <= 0;
		run(16'h0001, 16'h0000, 16'h0010, 2'h1);
		cmp(u_mem.m[16], 16'hdead);
		exec_cond <= 1;
	endtask
	task t_err;
		xf(1, 8'h10, 32'h0000_0012);
		for (k = 0; k < 6; k++) begin
			run(16'h0001, ec[k], ed[k], k > 3 ? 2'h3 : 2'h1);
			cmp({15'h0, error_flag}, 16'h1);
			cmp(u_mem.m[16], 16'hdead);
			xf(1, 8'h18, 32'h0000_0002);
			xf(0, 8'h18, 32'h0000_0000);
			cmp({15'h0, q[1]}, 16'h0);
		end
		xf(1, 8'h10, 32'h0000_ffff);
	endtask
	task test_done;
		$display("errors %0d compared %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge clk);
		rst_b <= 1;
		@(posedge clk);
		xf(0, 8'h10, 32'h0000_0000);
		cmp(q[15:0], 16'hffff);
		xf(0, 8'h40, 32'h0000_0000);
		cmp(q[15:0], 16'h0000);
		t_nib;
		t_byte;
		t_cond;
		t_err;
		test_done;
	end
	initial begin
		#2000000;
		num_errors++;
		test_done;
	end
endmodule

// >>> dv/dtb_checker.sv
`timescale 1ns/10ps
module dtb_checker #(parameter ADDR_W = 16) (
	// clock, reset
	input wire logic              clk,
	input wire logic              rst_b,
	input wire logic              ce,
	input wire logic              exec_cond,
	// bus
	input wire logic              hsel,
	input wire logic [31:0]       haddr,
	input wire logic [1:0]        htrans,
	input wire logic              hwrite,
	input wire logic [2:0]        hsize,
	input wire logic [31:0]       hwdata,
	input wire logic              hready,
	input wire logic [31:0]       hrdata,
	input wire logic              hreadyout,
	input wire logic              hresp,
	// memory, status
	input wire logic              mem_we,
	input wire logic [ADDR_W-1:0] mem_addr,
	input wire logic [15:0]       mem_wdata,
	input wire logic              busy,
	input wire logic              error_flag
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	sequence go_s; $rose(busy); endsequence
	sequence first_wr_s; !mem_we ##1 mem_we; endsequence
	ready_ce_a: assert property (hreadyout == ce) else $error("ready differs");
	resp_okay_a: assert property (!hresp) else $error("bad response");
	cond_start_a: assert property (go_s |-> $past(exec_cond))
		else $error("start without condition");
	we_busy_a: assert property (mem_we |-> $past(busy)) else $error("stray write");
	first_wr_a: assert property (go_s |-> first_wr_s) else $error("first write late");
	addr_step_a: assert property (mem_we && $past(mem_we) |->
		mem_addr == $past(mem_addr) + 1'b1) else $error("address skip");
	one_hot_a: assert property (mem_we |-> $onehot0(mem_wdata))
		else $error("word not one-hot");
	error_nowr_a: assert property ($rose(error_flag) |-> !busy ##1 !mem_we [*2])
		else $error("write after error");
	busy_bound_a: assert property (go_s |-> ##[1:40] !busy) else $error("busy hangs");
endmodule
bind dtb_decoder dtb_checker #(.ADDR_W(ADDR_W)) u_chk (.*);

// >>> dv/dtb_mem.sv
`timescale 1ns/10ps
module dtb_mem (
	// clock
	input wire logic        clk,
	// write port
	input wire logic        mem_we,
	input wire logic [15:0] mem_addr,
	input wire logic [15:0] mem_wdata
);
	logic [15:0] m [0:255];
	// accepts every write, no wait
	always @(posedge clk) begin
		if (mem_we) begin
			m[mem_addr[7:0]] <= mem_wdata;
		end
	end
endmodule

// >>> verilog/dtb_decoder.v
// Our own choices: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/10ps
// Functional notes
// (RULE1) control leftmost digit 0 selects nibble decode, 1 selects byte decode.
// (RULE2) nibble mode: issuer keeps both rightmost control digits within 0 to 3.
// (RULE3) byte mode: issuer keeps both rightmost control digits within 0 to 1.
// (RULE4) execution condition low: no decode, result words untouched.
// (RULE5) nibble mode: digit value sets that bit, other 15 bits cleared.
// (RULE6) nibble mode: up to 4 digits, one word each, consecutive from first word.
// (RULE7) first digit and count from control; past last digit wrap to digit zero.
// (RULE8) byte mode: byte sets one bit of 16-word group, other 255 cleared.
// (RULE9) byte mode: one or two bytes into consecutive groups; index 0 rightmost.
// (RULE10) undefined control word raises the error flag.
// (RULE11) result words crossing the area boundary raise the error flag.
// (RULE12) indirect pointer not BCD or outside the area raises the error flag.
// (RULE13) rightmost control digit is first item, next digit is count minus one.
`include "dtb_defs.vh"

module dtb_decoder #(
	parameter ADDR_W = 16
) (
	// clock, reset, enable
	input  wire              clk,
	input  wire              rst_b,
	input  wire              ce,
	// instruction sequencer
	input  wire              exec_cond,
	// ahb-lite slave
	input  wire              hsel,
	input  wire [31:0]       haddr,
	input  wire [1:0]        htrans,
	input  wire              hwrite,
	input  wire [2:0]        hsize,
	input  wire [31:0]       hwdata,
	input  wire              hready,
	output reg  [31:0]       hrdata,
	output wire              hreadyout,
	output wire              hresp,
	// data memory write port
	output reg               mem_we,
	output reg  [ADDR_W-1:0] mem_addr,
	output reg  [15:0]       mem_wdata,
	// status
	output wire              busy,
	output wire              error_flag
);

	////////////////////////////////////////////////////////////////////////
	// functions

	function [15:0] onehot16;
		input [3:0] pos;
		begin
			onehot16 = 16'h0001 << pos;
		end
	endfunction

	function reg_hit;
		input [7:0] a;
		input [7:0] ofs;
		begin
			reg_hit = (a == ofs);
		end
	endfunction

	function [15:0] bcd2bin;
		input [15:0] v;
		reg   [15:0] acc;
		begin
			acc = {12'h000, v[15:12]};
			acc = (acc * 16'h000A) + {12'h000, v[11:8]};
			acc = (acc * 16'h000A) + {12'h000, v[7:4]};
			acc = (acc * 16'h000A) + {12'h000, v[3:0]};
			bcd2bin = acc;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// registers and state

	localparam ST_IDLE = 1'b0;
	localparam ST_RUN  = 1'b1;

	reg              state;
	reg  [15:0]      src_word;
	reg  [15:0]      ctrl_word;
	reg  [15:0]      dst_word;
	reg  [15:0]      area_lo;
	reg  [15:0]      area_hi;
	reg              err;
	reg              done;
	reg              indirect;
	reg  [ADDR_W-1:0] cur_addr;
	reg  [1:0]       item;
	reg  [3:0]       word_in_grp;
	reg  [15:0]      run_src;
	reg              run_byte;
	reg  [1:0]       run_first;
	reg  [1:0]       run_last;

	reg              dp_valid;
	reg              dp_write;
	reg  [7:0]       dp_addr;

	assign hreadyout  = ce;
	assign hresp      = 1'b0;
	assign busy       = (state == ST_RUN);
	assign error_flag = err;

	////////////////////////////////////////////////////////////////////////
	// ahb address phase capture

	wire addr_take = hsel && htrans[1] && hready;

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			dp_valid <= 1'b0;
			dp_write <= 1'b0;
			dp_addr  <= 8'h00;
		end else if (ce) begin
			dp_valid <= addr_take;
			dp_write <= hwrite;
			dp_addr  <= haddr[7:0];
		end
	end

	wire wr_en    = dp_valid && dp_write;
	wire wr_cmd   = wr_en && reg_hit(dp_addr, `DTB_OFS_CMD);
	wire wr_stat  = wr_en && reg_hit(dp_addr, `DTB_OFS_STATUS);
	wire cfg_wr   = wr_en && (state == ST_IDLE);
	wire go       = wr_cmd && hwdata[`DTB_CMD_GO] && (state == ST_IDLE);

	////////////////////////////////////////////////////////////////////////
	// read data, registered at the address phase

	function [31:0] rd_word;
		input [7:0] a;
		begin
			case (a)
			`DTB_OFS_SRC:     rd_word = {16'h0000, src_word};
			`DTB_OFS_CTRL:    rd_word = {16'h0000, ctrl_word};
			`DTB_OFS_DST:     rd_word = {16'h0000, dst_word};
			`DTB_OFS_AREA_LO: rd_word = {16'h0000, area_lo};
			`DTB_OFS_AREA_HI: rd_word = {16'h0000, area_hi};
			`DTB_OFS_CMD:     rd_word = {30'h0000_0000, indirect, 1'b0};
			`DTB_OFS_STATUS:  rd_word = {29'h0000_0000, done, err, busy};
			default:          rd_word = 32'h0000_0000;
			endcase
		end
	endfunction

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			hrdata <= 32'h0000_0000;
		end else if (ce) begin
			if (addr_take && !hwrite)
				hrdata <= rd_word(haddr[7:0]);
			else
				hrdata <= 32'h0000_0000;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// start checks

	wire [3:0] mode_dig = ctrl_word[`DTB_CTRL_MODE_HI:`DTB_CTRL_MODE_LO];
	wire [3:0] cnt_dig  = ctrl_word[`DTB_CTRL_CNT_HI:`DTB_CTRL_CNT_LO];
	wire [3:0] fst_dig  = ctrl_word[`DTB_CTRL_FST_HI:`DTB_CTRL_FST_LO];

	wire is_nib  = (mode_dig == `DTB_MODE_NIBBLE); // RULE1
	wire is_byte = (mode_dig == `DTB_MODE_BYTE); // RULE1

	// field limits per mode
	wire nib_ok   = is_nib && (cnt_dig <= `DTB_NIB_MAX) && (fst_dig <= `DTB_NIB_MAX);
	wire byte_ok  = is_byte && (cnt_dig <= `DTB_BYTE_MAX) && (fst_dig <= `DTB_BYTE_MAX);
	wire ctrl_bad = !nib_ok && !byte_ok; // RULE10

	// pointer digits must each be decimal
	wire [3:0] ptr_dig_ok;
	genvar     gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_ptr_dig
			assign ptr_dig_ok[gi] = (dst_word[gi*4 +: 4] <= 4'h9);
		end
	endgenerate

	wire        use_ind  = hwdata[`DTB_CMD_INDIRECT];
	wire        ptr_bad  = use_ind && !(&ptr_dig_ok); // RULE12
	wire [15:0] eff_addr = use_ind ? bcd2bin(dst_word) : dst_word;

	// words to write: count+1 items, 16 words each in byte mode
	wire [16:0] n_words = is_byte ? ({13'h0000, cnt_dig} + 17'h0001) << 4 :
		{13'h0000, cnt_dig} + 17'h0001; // RULE13
	wire [16:0] last_addr = {1'b0, eff_addr} + n_words - 17'h0001;

	// RULE11 RULE12
	wire area_bad = (eff_addr < area_lo) || (last_addr > {1'b0, area_hi});
	wire start_err = ctrl_bad || ptr_bad || area_bad;

	////////////////////////////////////////////////////////////////////////
	// per-word result

	wire [1:0] sel_idx = run_first + item; // RULE7
	wire [3:0] nib_val = run_src[{sel_idx, 2'b00} +: 4];
	wire [7:0] byte_val = sel_idx[0] ? run_src[15:8] : run_src[7:0]; // RULE9

	reg [15:0] next_wdata;
	always @* begin
		if (run_byte) begin
			// RULE8
			next_wdata = (byte_val[7:4] == word_in_grp) ? onehot16(byte_val[3:0]) :
				16'h0000;
		end else begin
			next_wdata = onehot16(nib_val); // RULE5
		end
	end

	wire last_word = (item == run_last) && (!run_byte || (word_in_grp == 4'hF));

	////////////////////////////////////////////////////////////////////////
	// configuration registers

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			src_word  <= `DTB_RST_WORD;
			ctrl_word <= `DTB_RST_WORD;
			dst_word  <= `DTB_RST_WORD;
			area_lo   <= `DTB_RST_WORD;
			area_hi   <= `DTB_RST_AREA_HI;
			indirect  <= 1'b0;
		end else if (ce) begin
			if (cfg_wr && reg_hit(dp_addr, `DTB_OFS_SRC))
				src_word <= hwdata[15:0];
			if (cfg_wr && reg_hit(dp_addr, `DTB_OFS_CTRL))
				ctrl_word <= hwdata[15:0];
			if (cfg_wr && reg_hit(dp_addr, `DTB_OFS_DST))
				dst_word <= hwdata[15:0];
			if (cfg_wr && reg_hit(dp_addr, `DTB_OFS_AREA_LO))
				area_lo <= hwdata[15:0];
			if (cfg_wr && reg_hit(dp_addr, `DTB_OFS_AREA_HI))
				area_hi <= hwdata[15:0];
			if (cfg_wr && reg_hit(dp_addr, `DTB_OFS_CMD))
				indirect <= use_ind;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// status flags

	// start only when idle and the condition holds
	wire start_take = go && exec_cond; // RULE4
	wire run_step   = (state == ST_RUN);

	wire err_set  = start_take && start_err; // RULE10 RULE11 RULE12
	wire done_set = err_set || (run_step && last_word);
	wire err_clr  = wr_stat && hwdata[`DTB_ST_ERR];
	wire done_clr = wr_stat && hwdata[`DTB_ST_DONE];

	reg next_err;
	reg next_done;
	always @* begin
		next_err  = err;
		next_done = done;
		// write-one-to-clear; a set in the same cycle wins
		if (err_clr)
			next_err = 1'b0;
		if (done_clr)
			next_done = 1'b0;
		if (err_set)
			next_err = 1'b1;
		if (done_set)
			next_done = 1'b1;
	end

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			err  <= 1'b0;
			done <= 1'b0;
		end else if (ce) begin
			err  <= next_err;
			done <= next_done;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// data memory write port

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			mem_we    <= 1'b0;
			mem_addr  <= {ADDR_W{1'b0}};
			mem_wdata <= 16'h0000;
		end else if (ce) begin
			mem_we <= run_step; // RULE6
			if (run_step) begin
				mem_addr  <= cur_addr;
				mem_wdata <= next_wdata;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// decode sequencer

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state       <= ST_IDLE;
			cur_addr    <= {ADDR_W{1'b0}};
			item        <= 2'b00;
			word_in_grp <= 4'h0;
			run_src     <= `DTB_RST_WORD;
			run_byte    <= 1'b0;
			run_first   <= 2'b00;
			run_last    <= 2'b00;
		end else if (ce) begin
			case (state)
			ST_IDLE: begin
				if (start_take && !start_err) begin
					state       <= ST_RUN;
					cur_addr    <= eff_addr[ADDR_W-1:0];
					item        <= 2'b00;
					word_in_grp <= 4'h0;
					run_src     <= src_word;
					run_byte    <= is_byte;
					run_first   <= fst_dig[1:0]; // RULE13
					run_last    <= cnt_dig[1:0]; // RULE13
				end
			end
			ST_RUN: begin
				// one word per cycle, ascending addresses
				cur_addr    <= cur_addr + {{(ADDR_W-1){1'b0}}, 1'b1}; // RULE6
				word_in_grp <= word_in_grp + 4'h1;
				if (!run_byte || word_in_grp == 4'hF)
					item <= item + 2'b01;
				if (last_word)
					state <= ST_IDLE;
			end
			default: state <= ST_IDLE;
			endcase
		end
	end

endmodule

// >>> verilog/dtb_defs.vh
`ifndef DTB_DEFS_VH
`define DTB_DEFS_VH

// register byte offsets
`define DTB_OFS_SRC      8'h00
`define DTB_OFS_CTRL     8'h04
`define DTB_OFS_DST      8'h08
`define DTB_OFS_AREA_LO  8'h0C
`define DTB_OFS_AREA_HI  8'h10
`define DTB_OFS_CMD      8'h14
`define DTB_OFS_STATUS   8'h18

// command bits
`define DTB_CMD_GO       0
`define DTB_CMD_INDIRECT 1

// status bits
`define DTB_ST_BUSY      0
`define DTB_ST_ERR       1
`define DTB_ST_DONE      2

// control word fields
`define DTB_CTRL_MODE_HI 15
`define DTB_CTRL_MODE_LO 12
`define DTB_CTRL_CNT_HI  7
`define DTB_CTRL_CNT_LO  4
`define DTB_CTRL_FST_HI  3
`define DTB_CTRL_FST_LO  0

// mode digit values and field limits
`define DTB_MODE_NIBBLE  4'h0
`define DTB_MODE_BYTE    4'h1
`define DTB_NIB_MAX      4'h3
`define DTB_BYTE_MAX     4'h1

// reset values
`define DTB_RST_WORD     16'h0000
`define DTB_RST_AREA_HI  16'hFFFF

// words in one 256-bit group
`define DTB_GROUP_WORDS  5'h10

`endif
